// ### src/cale_exec.sv
// Execution unit for arithmetic, logic and control-flow instructions
`timescale 1ns/1ps
module cale_exec
  import cale_pkg::*;
(
  input  wire logic        clk_sys,   // Core clock, 200 MHz
  input  wire logic        rstn,      // Async reset, active low
  input  wire logic        clkEn,     // Freezes all state when low
  input  wire logic        reqValid,  // Sequencer issues an instruction
  input  wire cale_req_t   req,       // Instruction and operands
  output logic             busy,      // Multi-cycle instruction in progress
  output logic             done,      // Instruction retires this cycle
  output cale_res_t        result,    // Registered result
  output logic [7:0]       sreg,      // Status register
  output logic [15:0]      pc         // Program counter
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [0:0] {CALE_IDLE, CALE_WAIT} cale_state_t;

  cale_state_t state_q, state_d;   // Sequencing state
  logic [2:0]  cnt_q, cnt_d;       // Remaining cycles
  logic [7:0]  sreg_q, sreg_d;     // Flags
  logic [15:0] pc_q, pc_d;         // Program counter
  cale_res_t   res_q, res_d;       // Result carrier

  // ----------------------------------------
  // Byte add/sub with carry-in: returns {H,V,C,sum}
  // ----------------------------------------
  function automatic logic [10:0] cale_addsub(input logic [7:0] a, input logic [7:0] b,
                                              input logic cin, input logic sub);
    logic [8:0] s;
    logic [7:0] r;
    logic       h, v, c;
    s = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin}) : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
    r = s[7:0];
    c = s[8];
    if (sub) begin
      h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    end else begin
      h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
    end
    return {h, v, c, r};
  endfunction : cale_addsub

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [10:0] ar;
    logic [16:0] w;
    logic [15:0] pair;
    logic [7:0]  lg;
    logic [7:0]  f;
    logic [2:0]  cyc;
    logic        fArith, fLogic, fWord, keepC;
    ar     = '0;
    w      = '0;
    lg     = '0;
    cyc    = CALE_CYC_ONE;
    fArith = 1'b0;
    fLogic = 1'b0;
    fWord  = 1'b0;
    keepC  = 1'b0;
    pair   = {req.rdHigh, req.rd};
    f      = sreg_q;
    state_d = state_q;
    cnt_d   = cnt_q;
    sreg_d  = sreg_q;
    pc_d    = pc_q;
    res_d   = res_q;
    res_d.wrLow  = 1'b0;
    res_d.wrHigh = 1'b0;
    res_d.push   = 1'b0;
    case (state_q)
      CALE_IDLE: begin
        if (reqValid) begin
          pc_d = pc_q + CALE_PC_STEP;                   // Default fall-through
          case (req.op)
            CALE_OP_ADD_REGS: begin
              ar = cale_addsub(req.rd, req.rr, 1'b0, 1'b0);
              fArith = 1'b1;
            end
            CALE_OP_ADD_CARRY_REGS: begin
              ar = cale_addsub(req.rd, req.rr, sreg_q[CALE_FLAG_C], 1'b0);
              fArith = 1'b1;
            end
            CALE_OP_DIFFERENCE_REGS: begin
              ar = cale_addsub(req.rd, req.rr, 1'b0, 1'b1);
              fArith = 1'b1;
            end
            CALE_OP_DIFFERENCE_IMMEDIATE: begin
              ar = cale_addsub(req.rd, req.k, 1'b0, 1'b1);
              fArith = 1'b1;
            end
            CALE_OP_BORROW_DIFFERENCE_REGS: begin
              ar = cale_addsub(req.rd, req.rr, sreg_q[CALE_FLAG_C], 1'b1);
              fArith = 1'b1;
            end
            CALE_OP_BORROW_DIFFERENCE_IMMEDIATE: begin
              ar = cale_addsub(req.rd, req.k, sreg_q[CALE_FLAG_C], 1'b1);
              fArith = 1'b1;
            end
            CALE_OP_TWOS_INVERSION: begin
              ar = cale_addsub(CALE_ALL_ZERO, req.rd, 1'b0, 1'b1);
              fArith = 1'b1;
            end
            CALE_OP_COMPARE_REGS, CALE_OP_COMPARE_REGS_BORROW, CALE_OP_COMPARE_IMMEDIATE: begin
              // Flags only, destination untouched
              ar = cale_addsub(req.rd,
                               (req.op == CALE_OP_COMPARE_IMMEDIATE) ? req.k : req.rr,
                               (req.op == CALE_OP_COMPARE_REGS_BORROW) & sreg_q[CALE_FLAG_C],
                               1'b1);
              fArith = 1'b1;
            end
            CALE_OP_ONES_INVERSION: begin
              lg = CALE_ALL_ONES - req.rd;
              fLogic = 1'b1;
              keepC  = 1'b1;
            end
            CALE_OP_CONJ_REGS:              lg = req.rd & req.rr;
            CALE_OP_BITWISE_CONJ_IMMEDIATE: lg = req.rd & req.k;
            CALE_OP_DISJ_REGS:              lg = req.rd | req.rr;
            CALE_OP_BITWISE_DISJ_IMMEDIATE: lg = req.rd | req.k;
            CALE_OP_EXCLUSIVE_DISJ_REGS:    lg = req.rd ^ req.rr;
            CALE_OP_SET_BITS_MASK:          lg = req.rd | req.k;
            CALE_OP_CLEAR_BITS_MASK:        lg = req.rd & (CALE_ALL_ONES - req.k);
            CALE_OP_PLUS_ONE:               lg = req.rd + 8'h01;
            CALE_OP_MINUS_ONE:              lg = req.rd - 8'h01;
            CALE_OP_ZERO_SIGN_CHECK:        lg = req.rd & req.rd;
            CALE_OP_ZERO_REGISTER:          lg = req.rd ^ req.rd;
            CALE_OP_ALL_ONES_LOAD: begin
              res_d.res   = CALE_ALL_ONES;
              res_d.wrLow = 1'b1;
            end
            CALE_OP_WORD_IMMEDIATE_SUM: begin
              w = {1'b0, pair} + {9'h000, req.k};
              fWord = 1'b1;
              cyc = CALE_CYC_TWO;
            end
            CALE_OP_WORD_IMMEDIATE_DIFFERENCE: begin
              w = {1'b0, pair} - {9'h000, req.k};
              fWord = 1'b1;
              cyc = CALE_CYC_TWO;
            end
            CALE_OP_RELATIVE_GOTO: begin
              pc_d = pc_q + req.offset + CALE_PC_STEP;
              cyc  = CALE_CYC_TWO;
            end
            CALE_OP_POINTER_GOTO: begin
              pc_d = req.zPtr;
              cyc  = CALE_CYC_TWO;
            end
            CALE_OP_ABSOLUTE_GOTO: begin
              pc_d = req.target;
              cyc  = CALE_CYC_THREE;
            end
            CALE_OP_RELATIVE_SUBROUTINE_ENTRY: begin
              pc_d = pc_q + req.offset + CALE_PC_STEP;
              res_d.push   = 1'b1;
              res_d.pushPc = pc_q + CALE_PC_STEP;
              cyc = CALE_CYC_THREE;
            end
            CALE_OP_POINTER_SUBROUTINE_ENTRY: begin
              pc_d = req.zPtr;
              res_d.push   = 1'b1;
              res_d.pushPc = pc_q + CALE_PC_STEP;
              cyc = CALE_CYC_THREE;
            end
            CALE_OP_ABSOLUTE_SUBROUTINE_ENTRY: begin
              pc_d = req.target;
              res_d.push   = 1'b1;
              res_d.pushPc = pc_q + CALE_SKIP_SHORT;      // Past the two-word call
              cyc = CALE_CYC_FOUR;
            end
            CALE_OP_SUBROUTINE_EXIT: begin
              pc_d = req.stackPc;
              cyc  = CALE_CYC_FOUR;
            end
            CALE_OP_INTERRUPT_EXIT: begin
              pc_d = req.stackPc;
              sreg_d[CALE_FLAG_I] = 1'b1;
              cyc  = CALE_CYC_FOUR;
            end
            CALE_OP_EQUAL_SKIP: begin
              if (req.rd == req.rr) begin
                pc_d = pc_q + (req.nextLong ? CALE_SKIP_LONG : CALE_SKIP_SHORT);
                cyc  = req.nextLong ? CALE_CYC_THREE : CALE_CYC_TWO;
              end
            end
            default: ;                                    // No operation
          endcase
          // Byte arithmetic: write unless compare
          if (fArith) begin
            f[CALE_FLAG_H] = ar[10];
            f[CALE_FLAG_V] = ar[9];
            f[CALE_FLAG_C] = ar[8];
            f[CALE_FLAG_N] = ar[7];
            f[CALE_FLAG_Z] = (ar[7:0] == CALE_ALL_ZERO);
            res_d.res   = ar[7:0];
            res_d.wrLow = !(req.op inside {CALE_OP_COMPARE_REGS, CALE_OP_COMPARE_REGS_BORROW,
                                           CALE_OP_COMPARE_IMMEDIATE});
            sreg_d = f;
          end
          // Logic group: Z N V, V cleared except plus/minus one set it on overflow; ones inversion also sets C
          if (fLogic || req.op inside {CALE_OP_CONJ_REGS, CALE_OP_BITWISE_CONJ_IMMEDIATE,
              CALE_OP_DISJ_REGS, CALE_OP_BITWISE_DISJ_IMMEDIATE, CALE_OP_EXCLUSIVE_DISJ_REGS,
              CALE_OP_SET_BITS_MASK, CALE_OP_CLEAR_BITS_MASK, CALE_OP_PLUS_ONE,
              CALE_OP_MINUS_ONE, CALE_OP_ZERO_SIGN_CHECK, CALE_OP_ZERO_REGISTER}) begin
            f[CALE_FLAG_Z] = (lg == CALE_ALL_ZERO);
            f[CALE_FLAG_N] = lg[7];
            f[CALE_FLAG_V] = 1'b0;
            if (req.op == CALE_OP_PLUS_ONE)  f[CALE_FLAG_V] = (lg == 8'h80);
            if (req.op == CALE_OP_MINUS_ONE) f[CALE_FLAG_V] = (lg == 8'h7f);
            if (keepC) f[CALE_FLAG_C] = 1'b1;
            res_d.res   = lg;
            res_d.wrLow = (req.op != CALE_OP_ZERO_SIGN_CHECK);
            sreg_d = f;
          end
          // Word group: Z C N V S
          if (fWord) begin
            f[CALE_FLAG_Z] = (w[15:0] == 16'h0000);
            f[CALE_FLAG_N] = w[15];
            f[CALE_FLAG_C] = w[16];
            f[CALE_FLAG_V] = (req.op == CALE_OP_WORD_IMMEDIATE_SUM) ? (~pair[15] & w[15])
                                                                      : (pair[15] & ~w[15]);
            f[CALE_FLAG_S] = f[CALE_FLAG_N] ^ f[CALE_FLAG_V];
            res_d.res     = w[7:0];
            res_d.resHigh = w[15:8];
            res_d.wrLow   = 1'b1;
            res_d.wrHigh  = 1'b1;
            sreg_d = f;
          end
          if (cyc != CALE_CYC_ONE) begin                  // Hold off further requests
            state_d = CALE_WAIT;
            cnt_d   = cyc - CALE_CYC_ONE;
          end
        end
      end
      CALE_WAIT: begin
        cnt_d = cnt_q - CALE_CYC_ONE;
        if (cnt_q == CALE_CYC_ONE) state_d = CALE_IDLE;
      end
      default: state_d = CALE_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= CALE_IDLE;
      cnt_q   <= '0;
      sreg_q  <= CALE_SREG_RESET;
      pc_q    <= CALE_PC_RESET;
      res_q   <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sreg_q  <= sreg_d;
      pc_q    <= pc_d;
      res_q   <= res_d;
    end
  end

  // Retire pulse: last cycle of a wait, or an issue that stays idle
  // Reuses the next-state decode so cycle counts live in one place only
  assign busy   = (state_q == CALE_WAIT);
  assign done   = clkEn & ((state_q == CALE_IDLE & reqValid & state_d == CALE_IDLE) |
                           (busy & cnt_q == CALE_CYC_ONE));
  assign result = res_q;
  assign sreg   = sreg_q;
  assign pc     = pc_q;

endmodule : cale_exec

// ### src/cale_pkg.sv
// Package: opcodes, flag positions, cycle counts and carriers for the exec block
package cale_pkg;

  // ----------------------------------------
  // Operation codes from the sequencer
  // ----------------------------------------
  typedef enum logic [5:0] {
    CALE_OP_NONE,
    CALE_OP_ADD_REGS,
    CALE_OP_ADD_CARRY_REGS,
    CALE_OP_WORD_IMMEDIATE_SUM,
    CALE_OP_DIFFERENCE_REGS,
    CALE_OP_DIFFERENCE_IMMEDIATE,
    CALE_OP_BORROW_DIFFERENCE_REGS,
    CALE_OP_BORROW_DIFFERENCE_IMMEDIATE,
    CALE_OP_WORD_IMMEDIATE_DIFFERENCE,
    CALE_OP_CONJ_REGS,
    CALE_OP_BITWISE_CONJ_IMMEDIATE,
    CALE_OP_DISJ_REGS,
    CALE_OP_BITWISE_DISJ_IMMEDIATE,
    CALE_OP_EXCLUSIVE_DISJ_REGS,
    CALE_OP_ONES_INVERSION,
    CALE_OP_TWOS_INVERSION,
    CALE_OP_SET_BITS_MASK,
    CALE_OP_CLEAR_BITS_MASK,
    CALE_OP_PLUS_ONE,
    CALE_OP_MINUS_ONE,
    CALE_OP_ZERO_SIGN_CHECK,
    CALE_OP_ZERO_REGISTER,
    CALE_OP_ALL_ONES_LOAD,
    CALE_OP_RELATIVE_GOTO,
    CALE_OP_POINTER_GOTO,
    CALE_OP_ABSOLUTE_GOTO,
    CALE_OP_RELATIVE_SUBROUTINE_ENTRY,
    CALE_OP_POINTER_SUBROUTINE_ENTRY,
    CALE_OP_ABSOLUTE_SUBROUTINE_ENTRY,
    CALE_OP_SUBROUTINE_EXIT,
    CALE_OP_INTERRUPT_EXIT,
    CALE_OP_EQUAL_SKIP,
    CALE_OP_COMPARE_REGS,
    CALE_OP_COMPARE_REGS_BORROW,
    CALE_OP_COMPARE_IMMEDIATE
  } cale_op_t;

  // ----------------------------------------
  // Status register bit positions
  // ----------------------------------------
  localparam int CALE_FLAG_C = 0;
  localparam int CALE_FLAG_Z = 1;
  localparam int CALE_FLAG_N = 2;
  localparam int CALE_FLAG_V = 3;
  localparam int CALE_FLAG_S = 4;
  localparam int CALE_FLAG_H = 5;
  localparam int CALE_FLAG_T = 6;
  localparam int CALE_FLAG_I = 7;

  // ----------------------------------------
  // Constants and cycle counts
  // ----------------------------------------
  localparam logic [7:0]  CALE_ALL_ONES   = 8'hff;
  localparam logic [7:0]  CALE_ALL_ZERO   = 8'h00;
  localparam logic [7:0]  CALE_SREG_RESET = 8'h00;
  localparam logic [15:0] CALE_PC_RESET   = 16'h0000;
  localparam logic [15:0] CALE_PC_STEP    = 16'h0001;
  localparam logic [15:0] CALE_SKIP_SHORT = 16'h0002;
  localparam logic [15:0] CALE_SKIP_LONG  = 16'h0003;
  localparam logic [2:0]  CALE_CYC_ONE    = 3'h1;
  localparam logic [2:0]  CALE_CYC_TWO    = 3'h2;
  localparam logic [2:0]  CALE_CYC_THREE  = 3'h3;
  localparam logic [2:0]  CALE_CYC_FOUR   = 3'h4;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    cale_op_t    op;        // Operation to execute
    logic [7:0]  rd;        // Destination / low of pair
    logic [7:0]  rdHigh;    // High of register pair
    logic [7:0]  rr;        // Source register
    logic [7:0]  k;         // Immediate constant
    logic [15:0] offset;    // Signed relative offset
    logic [15:0] target;    // Absolute address operand
    logic [15:0] zPtr;      // Z pointer pair
    logic [15:0] stackPc;   // Popped return address
    logic        nextLong;  // Skipped instruction is two words
  } cale_req_t;

  typedef struct packed {
    logic [7:0]  res;       // Result low byte
    logic [7:0]  resHigh;   // Result high byte for word ops
    logic        wrLow;     // Write result to rd
    logic        wrHigh;    // Write resHigh to pair high
    logic        push;      // Push return address
    logic [15:0] pushPc;    // Return address to push
  } cale_res_t;

endpackage : cale_pkg

// ### testbench/cale_exec_properties.sv
// Checker: concurrent properties on the exec block ports
`timescale 1ns/1ps
module cale_exec_properties
  import cale_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        clkEn,
  input wire logic        reqValid,
  input wire cale_req_t   req,
  input wire logic        busy,
  input wire logic        done,
  input wire cale_res_t   result,
  input wire logic [7:0]  sreg,
  input wire logic [15:0] pc
);
  // ----------------------------------------
  // Clocking and acceptance
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  logic take; // Instruction accepted at this edge
  assign take = clkEn && reqValid && !busy;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_add_sum_written: assert property (
    take && req.op == CALE_OP_ADD_REGS |=>
    result.wrLow && result.res == $past(req.rd) + $past(req.rr)) else $error("add sum wrong");
  a_word_sum_len: assert property (
    take && req.op == CALE_OP_WORD_IMMEDIATE_SUM |=>
    (busy && done && {result.resHigh, result.res} == $past({req.rdHigh, req.rd}) + $past(req.k))
    ##1 !busy) else $error("word sum wrong");
  a_logic_keeps_carry: assert property (
    take && req.op inside {CALE_OP_CONJ_REGS, CALE_OP_DISJ_REGS, CALE_OP_EXCLUSIVE_DISJ_REGS,
    CALE_OP_PLUS_ONE, CALE_OP_MINUS_ONE} |=>
    $stable(sreg[CALE_FLAG_C]) && $stable(sreg[CALE_FLAG_H])) else $error("logic touched C or H");
  a_flow_keeps_flags: assert property (
    take && req.op inside {CALE_OP_RELATIVE_GOTO, CALE_OP_POINTER_GOTO, CALE_OP_ABSOLUTE_GOTO,
    CALE_OP_EQUAL_SKIP, CALE_OP_ALL_ONES_LOAD} |=> $stable(sreg)) else $error("flags changed");
  a_pointer_goto_len: assert property (
    take && req.op == CALE_OP_POINTER_GOTO |=>
    (busy && done && pc == $past(req.zPtr)) ##1 !busy) else $error("pointer goto wrong");
  a_abs_call_len: assert property (
    take && req.op == CALE_OP_ABSOLUTE_SUBROUTINE_ENTRY |=>
    (busy && !done && result.push) ##1 (busy && !done) ##1 (busy && done) ##1 !busy)
    else $error("absolute call timing wrong");
  a_skip_long_pc: assert property (
    take && req.op == CALE_OP_EQUAL_SKIP && req.rd == req.rr && req.nextLong |=>
    pc == $past(pc) + CALE_SKIP_LONG) else $error("long skip pc wrong");
  a_compare_no_write: assert property (
    take && req.op inside {CALE_OP_COMPARE_REGS, CALE_OP_COMPARE_REGS_BORROW} |=>
    !result.wrLow && !result.wrHigh) else $error("compare wrote a register");
  a_exit_pops_pc: assert property (
    take && req.op inside {CALE_OP_SUBROUTINE_EXIT, CALE_OP_INTERRUPT_EXIT} |=>
    (busy && pc == $past(req.stackPc)) ##1 busy[*2] ##1 !busy) else $error("return wrong");
  a_interrupt_exit_sets_i: assert property (
    take && req.op == CALE_OP_INTERRUPT_EXIT |=> sreg[CALE_FLAG_I]) else $error("I not set");
  a_busy_holds_pc: assert property (
    busy |=> $stable(pc)) else $error("pc moved while busy");

  // Main scenarios reached
  c_add: cover property (take && req.op == CALE_OP_ADD_REGS);
  c_interrupt_exit: cover property (take && req.op == CALE_OP_INTERRUPT_EXIT);
  c_skip: cover property (take && req.op == CALE_OP_EQUAL_SKIP && req.nextLong);
endmodule : cale_exec_properties

bind cale_exec cale_exec_properties u_cale_exec_properties (
  .clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .reqValid(reqValid), .req(req),
  .busy(busy), .done(done), .result(result), .sreg(sreg), .pc(pc));

// ### testbench/tb_top.sv
// Testbench: directed scenarios for the exec block
`timescale 1ns/1ps
module tb_top;
  import cale_pkg::*;
  logic        clk_sys  = 1'b0; // 200 MHz core clock
  logic        rstn     = 1'b0; // Reset held at start
  logic        clkEn    = 1'b1; // Dropped once to test freeze
  logic        reqValid = 1'b0; // Issue strobe
  cale_req_t   rq       = '0;   // Operands to the block
  logic        busy;
  logic        done;
  cale_res_t   result;
  logic [7:0]  sreg;
  logic [7:0]  prevF;           // Flags before the op
  logic [15:0] pc;
  logic [15:0] epc;             // Expected program counter
  logic        wrSeen;          // Strobes caught in cycle after issue
  logic        pushSeen;
  logic [15:0] pushSeenPc;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          cyc;             // Cycles the op took

  always #2.5 clk_sys = ~clk_sys;

  cale_exec u_cale_exec (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .reqValid(reqValid),
    .req(rq), .busy(busy), .done(done), .result(result), .sreg(sreg), .pc(pc));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Issue rq for one cycle, then count cycles until done; bounded
  task automatic go();
    logic dn;
    prevF = sreg;
    @(negedge clk_sys);
    reqValid = 1'b1;
    #1;
    dn  = done;
    cyc = 1;
    @(negedge clk_sys);
    reqValid   = 1'b0;
    wrSeen     = result.wrLow;
    pushSeen   = result.push;
    pushSeenPc = result.pushPc;
    while (dn !== 1'b1) begin
      if (cyc > 6) begin
        chk(1, 0);
        finish_test();
      end
      #1;
      dn = done;
      cyc++;
      @(negedge clk_sys);
    end
  endtask : go

  // One-cycle byte op: result, write strobe, updated and kept flags, pc+1
  task automatic alu(input cale_op_t op, input logic [7:0] d, s, kk, er, input logic wr,
                     input logic [7:0] upd, ef, keep);
    rq    = '0;
    rq.op = op;
    rq.rd = d;
    rq.rr = s;
    rq.k  = kk;
    go();
    epc = epc + 16'h0001;
    chk(cyc, 1);
    chk(wrSeen, wr);
    if (wr === 1'b1) chk(result.res, er);
    chk(sreg & upd, ef);
    chk(sreg & keep, prevF & keep);
    chk(pc, epc);
  endtask : alu

  // Two-cycle word op on the register pair
  task automatic wd(input cale_op_t op, input logic [15:0] w, input logic [7:0] kk,
                    input logic [15:0] ew, input logic [7:0] ef);
    rq        = '0;
    rq.op     = op;
    rq.rdHigh = w[15:8];
    rq.rd     = w[7:0];
    rq.k      = kk;
    go();
    epc = epc + 16'h0001;
    chk(cyc, 2);
    chk(wrSeen, 1'b1);
    chk(pc, epc);
    chk({result.resHigh, result.res}, ew);
    chk(sreg & 8'h1f, ef);
    chk(sreg & 8'he0, prevF & 8'he0);
  endtask : wd

  // Control-flow op; epp is the pushed return address, zero when none
  task automatic fl(input cale_op_t op, input logic [15:0] o, input logic nl, input int ecyc,
                    input logic [15:0] npc, epp);
    rq          = '0;
    rq.op       = op;
    rq.offset   = o;
    rq.target   = o;
    rq.zPtr     = o;
    rq.stackPc  = o;
    rq.rd       = o[7:0];
    rq.rr       = o[15:8];
    rq.nextLong = nl;
    go();
    chk(cyc, ecyc);
    chk(pc, npc);
    chk(pushSeen, |epp);
    if (|epp) chk(pushSeenPc, epp);
    chk(sreg & 8'h7f, prevF & 8'h7f);
    epc = npc;
  endtask : fl

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_arith;
    alu(CALE_OP_ADD_REGS, 8'h7f, 8'h01, 8'h00, 8'h80, 1, 8'h2f, 8'h2c, 8'hc0);
    alu(CALE_OP_ADD_REGS, 8'hff, 8'h01, 8'h00, 8'h00, 1, 8'h2f, 8'h23, 8'hc0);
    alu(CALE_OP_ADD_CARRY_REGS, 8'h10, 8'h20, 8'h00, 8'h31, 1, 8'h2f, 8'h00, 8'hc0);
    alu(CALE_OP_DIFFERENCE_REGS, 8'h10, 8'h20, 8'h00, 8'hf0, 1, 8'h2f, 8'h05, 8'hc0);
    alu(CALE_OP_BORROW_DIFFERENCE_REGS, 8'h05, 8'h02, 8'h00, 8'h02, 1, 8'h2f, 8'h00, 8'hc0);
    alu(CALE_OP_DIFFERENCE_IMMEDIATE, 8'h80, 8'h00, 8'h01, 8'h7f, 1, 8'h2f, 8'h28, 8'hc0);
    alu(CALE_OP_BORROW_DIFFERENCE_IMMEDIATE, 8'h03, 8'h00, 8'h05, 8'hfe, 1, 8'h2f, 8'h25,
        8'hc0);
    alu(CALE_OP_COMPARE_REGS, 8'h05, 8'h05, 8'h00, 8'h00, 0, 8'h2f, 8'h02, 8'hc0);
    alu(CALE_OP_COMPARE_REGS_BORROW, 8'h10, 8'h0f, 8'h00, 8'h00, 0, 8'h2f, 8'h20, 8'hc0);
    alu(CALE_OP_COMPARE_IMMEDIATE, 8'h40, 8'h00, 8'h41, 8'h00, 0, 8'h2f, 8'h25, 8'hc0);
    $display("t_arith done");
  endtask : t_arith

  // Carry and half carry are set on entry and must survive the logic group
  task t_logic;
    alu(CALE_OP_CONJ_REGS, 8'hf0, 8'h3c, 8'h00, 8'h30, 1, 8'h0e, 8'h00, 8'he1);
    alu(CALE_OP_BITWISE_CONJ_IMMEDIATE, 8'h0f, 8'h00, 8'hf0, 8'h00, 1, 8'h0e, 8'h02, 8'he1);
    alu(CALE_OP_DISJ_REGS, 8'h80, 8'h01, 8'h00, 8'h81, 1, 8'h0e, 8'h04, 8'he1);
    alu(CALE_OP_BITWISE_DISJ_IMMEDIATE, 8'h00, 8'h00, 8'h00, 8'h00, 1, 8'h0e, 8'h02, 8'he1);
    alu(CALE_OP_EXCLUSIVE_DISJ_REGS, 8'haa, 8'haa, 8'h00, 8'h00, 1, 8'h0e, 8'h02, 8'he1);
    alu(CALE_OP_SET_BITS_MASK, 8'h10, 8'h00, 8'h81, 8'h91, 1, 8'h0e, 8'h04, 8'he1);
    alu(CALE_OP_CLEAR_BITS_MASK, 8'ha5, 8'h00, 8'h0f, 8'ha0, 1, 8'h0e, 8'h04, 8'he1);
    alu(CALE_OP_ALL_ONES_LOAD, 8'h12, 8'h00, 8'h00, 8'hff, 1, 8'h00, 8'h00, 8'hff);
    alu(CALE_OP_ZERO_SIGN_CHECK, 8'h80, 8'h00, 8'h00, 8'h00, 0, 8'h0e, 8'h04, 8'he1);
    alu(CALE_OP_ZERO_REGISTER, 8'h5a, 8'h00, 8'h00, 8'h00, 1, 8'h0e, 8'h02, 8'he1);
    alu(CALE_OP_PLUS_ONE, 8'h7f, 8'h00, 8'h00, 8'h80, 1, 8'h0e, 8'h0c, 8'he1);
    alu(CALE_OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h7f, 1, 8'h0e, 8'h08, 8'he1);
    alu(CALE_OP_ONES_INVERSION, 8'h55, 8'h00, 8'h00, 8'haa, 1, 8'h0f, 8'h05, 8'hc0);
    alu(CALE_OP_TWOS_INVERSION, 8'h01, 8'h00, 8'h00, 8'hff, 1, 8'h2f, 8'h25, 8'hc0);
    $display("t_logic done");
  endtask : t_logic

  task t_word;
    wd(CALE_OP_WORD_IMMEDIATE_SUM, 16'h00ff, 8'h01, 16'h0100, 8'h00);
    wd(CALE_OP_WORD_IMMEDIATE_DIFFERENCE, 16'h8000, 8'h01, 16'h7fff, 8'h18);
    $display("t_word done");
  endtask : t_word

  task t_flow;
    fl(CALE_OP_RELATIVE_GOTO, 16'h0010, 0, 2, epc + 16'h0011, 16'h0000);
    fl(CALE_OP_POINTER_GOTO, 16'h0200, 0, 2, 16'h0200, 16'h0000);
    fl(CALE_OP_ABSOLUTE_GOTO, 16'h1234, 0, 3, 16'h1234, 16'h0000);
    fl(CALE_OP_RELATIVE_SUBROUTINE_ENTRY, 16'hfff0, 0, 3, epc + 16'hfff1, epc + 16'h0001);
    fl(CALE_OP_POINTER_SUBROUTINE_ENTRY, 16'h0300, 0, 3, 16'h0300, epc + 16'h0001);
    fl(CALE_OP_ABSOLUTE_SUBROUTINE_ENTRY, 16'h0400, 0, 4, 16'h0400, epc + 16'h0002);
    fl(CALE_OP_SUBROUTINE_EXIT, 16'h0123, 0, 4, 16'h0123, 16'h0000);
    chk(sreg[CALE_FLAG_I], 1'b0);
    fl(CALE_OP_INTERRUPT_EXIT, 16'h0456, 0, 4, 16'h0456, 16'h0000);
    chk(sreg[CALE_FLAG_I], 1'b1);
    fl(CALE_OP_EQUAL_SKIP, 16'h3333, 0, 2, epc + 16'h0002, 16'h0000);
    fl(CALE_OP_EQUAL_SKIP, 16'h3333, 1, 3, epc + 16'h0003, 16'h0000);
    fl(CALE_OP_EQUAL_SKIP, 16'h3433, 1, 1, epc + 16'h0001, 16'h0000);
    $display("t_flow done");
  endtask : t_flow

  // Request held during a jump is refused; a low clock enable freezes all
  task t_refuse;
    rq        = '0;
    rq.op     = CALE_OP_ABSOLUTE_GOTO;
    rq.target = 16'h0040;
    @(negedge clk_sys);
    reqValid = 1'b1;
    @(negedge clk_sys);
    rq.op = CALE_OP_ADD_REGS;
    chk(busy, 1'b1);
    @(negedge clk_sys);
    chk(busy, 1'b1);
    reqValid = 1'b0;
    @(negedge clk_sys);
    chk(busy, 1'b0);
    chk(pc, 16'h0040);
    chk(result.wrLow, 1'b0);
    clkEn    = 1'b0;
    reqValid = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(pc, 16'h0040);
    reqValid = 1'b0;
    clkEn    = 1'b1;
    @(negedge clk_sys);
    chk(pc, 16'h0040);
    $display("t_refuse done");
  endtask : t_refuse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    epc = 16'h0000;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    chk(pc, 16'h0000);
    chk(sreg, 8'h00);
    t_arith();
    t_logic();
    t_word();
    t_flow();
    t_refuse();
    finish_test();
  end
endmodule : tb_top
